// File: rtl/tsmsel_pkg.sv
/*
 tsmsel_pkg: register offsets, field positions, reset values and frame
 sizes for the thermal shutdown and measure select block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package tsmsel_pkg;
   // register addresses on the serial register port
   localparam logic [6:0]  ADDR_DPS1      = 7'h02;
   localparam logic [6:0]  ADDR_DPS2      = 7'h03;
   localparam logic [6:0]  ADDR_DIAG      = 7'h07;
   localparam logic [6:0]  ADDR_ALARM     = 7'h44;

   // power-supply control register one
   localparam int          DPS1_SOFT_INH  = 15;
   localparam int          DPS1_PDOWN     = 14;
   localparam int          DPS1_SRC_HI    = 13;
   localparam int          DPS1_SRC_LO    = 12;
   localparam int          DPS1_MEAS_TRI  = 11;
   localparam int          DPS1_RANGE_HI  = 10;
   localparam int          DPS1_RANGE_LO  = 8;
   localparam logic [15:0] DPS1_MASK      = 16'hff00;
   localparam logic [15:0] DPS1_RESET     = 16'h0000;

   // power-supply control register two
   localparam int          DPS2_THR_HI    = 15;
   localparam int          DPS2_THR_LO    = 14;
   localparam int          DPS2_LATCHED   = 13;
   localparam int          DPS2_SCALE     = 12;
   localparam int          DPS2_CUR_GAIN  = 11;
   localparam int          DPS2_LOW_RANGE = 10;
   localparam logic [15:0] DPS2_MASK      = 16'hfc00;
   localparam logic [15:0] DPS2_RESET     = 16'hc000;

   // diagnostic select register
   localparam int          DIAG_MEAS_EN   = 15;
   localparam int          DIAG_NODE_HI   = 13;
   localparam int          DIAG_NODE_LO   = 12;
   localparam int          DIAG_DIODE_EN  = 4;
   localparam int          DIAG_DIODE_HI  = 3;
   localparam int          DIAG_DIODE_LO  = 0;
   localparam logic [15:0] DIAG_MASK      = 16'hb01f;
   localparam logic [15:0] DIAG_RESET     = 16'h0000;

   // alarm status bits
   localparam int          ALM_FLAG       = 0;
   localparam int          ALM_LIVE       = 1;

   // trip thresholds: 100, 110, 120, 130 degrees
   localparam logic [1:0]  THR_100C       = 2'h0;
   localparam logic [1:0]  THR_130C       = 2'h3;

   // current range codes
   localparam logic [2:0]  RANGE_25MA     = 3'h4;
   localparam logic [2:0]  RANGE_EXT1     = 3'h5;
   localparam logic [2:0]  RANGE_EXT2     = 3'h6;

   // sensor select codes on stage_sensor_sel_out; TSMSEL_SENS_MID picks trip input bit 2
   typedef enum logic [1:0] {
      TSMSEL_SENS_ONE = 2'b00,
      TSMSEL_SENS_TWO = 2'b01,
      TSMSEL_SENS_MID = 2'b11
   } tsmsel_sensor_t;

   // serial frame: read flag, 7 address bits, 16 data bits
   localparam logic [4:0]  FRAME_LAST     = 5'h17;
   localparam logic [4:0]  CMD_LAST       = 5'h07;
   localparam logic        MEAS_DIAG_SET  = 1'b1;
endpackage

// File: rtl/tsmsel_sync2.sv
/*
 tsmsel_sync2: two flip-flop synchroniser for a bus of independent levels.
 Assumes each bit is a slow level; multi-bit coherence is not kept.
*/
`timescale 1ns/1ns
`default_nettype none
module tsmsel_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_sys_in,
   input  wire logic             sys_rst_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         stage1   <= '0;
         sync_out <= '0;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule
`default_nettype wire

// File: rtl/tsmsel_serial_port.sv
/*
 tsmsel_serial_port: 24-bit serial register frame decoder.
 Assumes sclk, sdi and frame select are already synchronised and that
 each sclk phase lasts at least four system clocks.
*/
`timescale 1ns/1ns
`default_nettype none
module tsmsel_serial_port (
   input  wire logic        clk_sys_in,
   input  wire logic        sys_rst_in,
   input  wire logic        sclk_in,
   input  wire logic        sdi_in,
   input  wire logic        sync_n_in,
   input  wire logic [15:0] rd_data_in,
   output logic             wr_pulse_out,
   output logic             rd_pulse_out,
   output logic [6:0]       addr_out,
   output logic [15:0]      wr_data_out,
   output logic             sdo_out,
   output logic             sdo_oe_n_out
);
   logic        sclk_q;
   logic [4:0]  bit_cnt;
   logic [22:0] shreg;
   logic [15:0] txreg;

   wire sclk_rise = sclk_in & ~sclk_q & ~sync_n_in;
   wire sclk_fall = ~sclk_in & sclk_q & ~sync_n_in;
   wire cmd_done  = sclk_rise & (bit_cnt == tsmsel_pkg::CMD_LAST) & shreg[6];
   wire frm_done  = sclk_rise & (bit_cnt == tsmsel_pkg::FRAME_LAST) & ~shreg[22];

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         sclk_q       <= 1'b0;
         bit_cnt      <= 5'h00;
         shreg        <= 23'h000000;
         wr_pulse_out <= 1'b0;
         rd_pulse_out <= 1'b0;
         addr_out     <= 7'h00;
         wr_data_out  <= 16'h0000;
      end else begin
         sclk_q       <= sclk_in;
         wr_pulse_out <= frm_done;
         rd_pulse_out <= cmd_done;
         if (sync_n_in) begin
            bit_cnt <= 5'h00;
         end else if (sclk_rise) begin
            bit_cnt <= bit_cnt + 5'h01;
            shreg   <= {shreg[21:0], sdi_in};
         end
         if (cmd_done) begin
            addr_out <= {shreg[5:0], sdi_in};
         end
         if (frm_done) begin
            addr_out    <= shreg[21:15];
            wr_data_out <= {shreg[14:0], sdi_in};
         end
      end
   end

   // read data leaves msb first on falling sclk
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         txreg        <= 16'h0000;
         sdo_out      <= 1'b0;
         sdo_oe_n_out <= 1'b1;
      end else begin
         sdo_oe_n_out <= sync_n_in;
         if (rd_pulse_out) begin
            txreg <= rd_data_in;
         end else if (sclk_fall) begin
            sdo_out <= txreg[15];
            txreg   <= {txreg[14:0], 1'b0};
         end
      end
   end
endmodule
`default_nettype wire

// File: rtl/tsmsel_thermal_measure.sv
/*
 tsmsel_thermal_measure: thermal shutdown control and measure output
 selection behind a serial register port.
 Assumes analog comparators report each stage sensor against the selected
 threshold, and the analog muxes obey the select outputs.
*/
`timescale 1ns/1ns
`default_nettype none

module tsmsel_thermal_measure (
   input  wire logic        clk_sys_in,
   input  wire logic        sys_rst_in,
   input  wire logic        sclk_in,
   input  wire logic        sdi_in,
   input  wire logic        sync_n_in,
   input  wire logic [2:0]  stage_trip_in,
   output logic             sdo_out,
   output logic             sdo_oe_n_out,
   output logic             force_enable_out,
   output logic             overtemp_alarm_pin_out,
   output logic             overtemp_alarm_pin_oe_n_out,
   output logic [1:0]       thresh_sel_out,
   output logic [1:0]       stage_sensor_sel_out,
   output logic             stage_sensor_enable_out,
   output logic [2:0]       range_sel_out,
   output logic [2:0]       meas_route_out,
   output logic             measure_output_tristate_out,
   output logic             meas_low_range_out,
   output logic             output_scale_select_out,
   output logic             current_gain_select_out,
   output logic             diode_probe_enable_out,
   output logic [3:0]       diode_probe_sel_out
);
   logic [2:0]  pin_sync;
   logic [2:0]  trip_sync;
   logic        wr_pulse;
   logic        rd_pulse;
   logic [6:0]  reg_addr;
   logic [15:0] wr_data;
   logic [15:0] rd_data;
   logic [15:0] dps1;
   logic [15:0] dps2;
   logic [15:0] diag;
   logic        alarm_flag;
   logic        shutdown_hold;
   logic [15:0] next_dps1;
   logic        next_alarm_flag;
   logic        next_hold;
   tsmsel_pkg::tsmsel_sensor_t sensor_sel;

   tsmsel_sync2 #(
      .WIDTH (3)
   ) u_pin_sync (
      .clk_sys_in (clk_sys_in),
      .sys_rst_in (sys_rst_in),
      .async_in   ({sclk_in, sdi_in, ~sync_n_in}),
      .sync_out   (pin_sync)
   );

   tsmsel_sync2 #(
      .WIDTH (3)
   ) u_trip_sync (
      .clk_sys_in (clk_sys_in),
      .sys_rst_in (sys_rst_in),
      .async_in   (stage_trip_in),
      .sync_out   (trip_sync)
   );

   tsmsel_serial_port u_port (
      .clk_sys_in   (clk_sys_in),
      .sys_rst_in   (sys_rst_in),
      .sclk_in      (pin_sync[2]),
      .sdi_in       (pin_sync[1]),
      .sync_n_in    (~pin_sync[0]),
      .rd_data_in   (rd_data),
      .wr_pulse_out (wr_pulse),
      .rd_pulse_out (rd_pulse),
      .addr_out     (reg_addr),
      .wr_data_out  (wr_data),
      .sdo_out      (sdo_out),
      .sdo_oe_n_out (sdo_oe_n_out)
   );

   // address decode
   wire wr_dps1  = wr_pulse & (reg_addr == tsmsel_pkg::ADDR_DPS1);
   wire wr_dps2  = wr_pulse & (reg_addr == tsmsel_pkg::ADDR_DPS2);
   wire wr_diag  = wr_pulse & (reg_addr == tsmsel_pkg::ADDR_DIAG);
   wire rd_alarm = rd_pulse & (reg_addr == tsmsel_pkg::ADDR_ALARM);

   // register fields
   wire        power_down    = dps1[tsmsel_pkg::DPS1_PDOWN];
   wire [2:0]  range_sel     = dps1[tsmsel_pkg::DPS1_RANGE_HI:tsmsel_pkg::DPS1_RANGE_LO];
   wire [1:0]  meas_src      = dps1[tsmsel_pkg::DPS1_SRC_HI:tsmsel_pkg::DPS1_SRC_LO];
   wire        alarm_latched = dps2[tsmsel_pkg::DPS2_LATCHED];
   wire [1:0]  diag_node     = diag[tsmsel_pkg::DIAG_NODE_HI:tsmsel_pkg::DIAG_NODE_LO];
   wire        diag_meas_en  = diag[tsmsel_pkg::DIAG_MEAS_EN];

   // sensor follows the active stage
   assign sensor_sel = (range_sel == tsmsel_pkg::RANGE_EXT2) ? tsmsel_pkg::TSMSEL_SENS_TWO :
                       (range_sel == tsmsel_pkg::RANGE_25MA) ? tsmsel_pkg::TSMSEL_SENS_MID :
                       tsmsel_pkg::TSMSEL_SENS_ONE;

   wire sensor_hot = (sensor_sel == tsmsel_pkg::TSMSEL_SENS_TWO) ? trip_sync[1] :
                     (sensor_sel == tsmsel_pkg::TSMSEL_SENS_MID) ? trip_sync[2] :
                     trip_sync[0];
   wire trip_now   = sensor_hot & ~power_down;

   // re-enable only once the alarm has been read away
   wire rearm = wr_dps1 & wr_data[tsmsel_pkg::DPS1_SOFT_INH] & ~alarm_flag;

   wire [15:0] alarm_word = {14'h0000, trip_now, alarm_flag};
   assign rd_data         = (reg_addr == tsmsel_pkg::ADDR_DPS1)  ? dps1 :
                            (reg_addr == tsmsel_pkg::ADDR_DPS2)  ? dps2 :
                            (reg_addr == tsmsel_pkg::ADDR_DIAG)  ? diag :
                            (reg_addr == tsmsel_pkg::ADDR_ALARM) ? alarm_word :
                            16'h0000;

   // trip clears soft inhibit over any write
   always_comb begin
      next_dps1 = dps1;
      if (wr_dps1) begin
         next_dps1 = wr_data & tsmsel_pkg::DPS1_MASK;
      end
      if (trip_now) begin
         next_dps1[tsmsel_pkg::DPS1_SOFT_INH] = 1'b0;
      end
   end

   assign next_alarm_flag = trip_now | (alarm_flag & ~rd_alarm);
   assign next_hold       = trip_now | (shutdown_hold & ~rearm);

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         dps1          <= tsmsel_pkg::DPS1_RESET;
         dps2          <= tsmsel_pkg::DPS2_RESET;
         diag          <= tsmsel_pkg::DIAG_RESET;
         alarm_flag    <= 1'b0;
         shutdown_hold <= 1'b0;
      end else begin
         dps1          <= next_dps1;
         dps2          <= wr_dps2 ? (wr_data & tsmsel_pkg::DPS2_MASK) : dps2;
         diag          <= wr_diag ? (wr_data & tsmsel_pkg::DIAG_MASK) : diag;
         alarm_flag    <= next_alarm_flag;
         shutdown_hold <= next_hold;
      end
   end

   // force stage enable and open-drain alarm
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         force_enable_out            <= 1'b0;
         overtemp_alarm_pin_oe_n_out <= 1'b1;
      end else begin
         force_enable_out <= next_dps1[tsmsel_pkg::DPS1_SOFT_INH] & ~next_hold;
         overtemp_alarm_pin_oe_n_out <= alarm_latched ? ~next_alarm_flag : ~trip_now;
      end
   end

   assign overtemp_alarm_pin_out = 1'b0;

   // analog select outputs
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         thresh_sel_out              <= tsmsel_pkg::THR_130C;
         stage_sensor_sel_out        <= tsmsel_pkg::TSMSEL_SENS_ONE;
         stage_sensor_enable_out     <= 1'b0;
         range_sel_out               <= 3'h0;
         meas_route_out              <= 3'h0;
         measure_output_tristate_out <= 1'b0;
         meas_low_range_out          <= 1'b0;
         output_scale_select_out     <= 1'b0;
         current_gain_select_out     <= 1'b0;
         diode_probe_enable_out      <= 1'b0;
         diode_probe_sel_out         <= 4'h0;
      end else begin
         thresh_sel_out <= dps2[tsmsel_pkg::DPS2_THR_HI:tsmsel_pkg::DPS2_THR_LO];
         stage_sensor_sel_out    <= sensor_sel;
         stage_sensor_enable_out <= ~power_down;
         range_sel_out           <= range_sel;
         meas_route_out <= diag_meas_en ? {tsmsel_pkg::MEAS_DIAG_SET, diag_node}
                                        : {1'b0, meas_src};
         measure_output_tristate_out <= dps1[tsmsel_pkg::DPS1_MEAS_TRI];
         meas_low_range_out      <= dps2[tsmsel_pkg::DPS2_LOW_RANGE];
         output_scale_select_out <= dps2[tsmsel_pkg::DPS2_SCALE];
         current_gain_select_out <= dps2[tsmsel_pkg::DPS2_CUR_GAIN];
         diode_probe_enable_out  <= diag[tsmsel_pkg::DIAG_DIODE_EN];
         diode_probe_sel_out <= diag[tsmsel_pkg::DIAG_DIODE_HI:tsmsel_pkg::DIAG_DIODE_LO];
      end
   end

   // checks
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (sys_rst_in);

   chk_thresh_default: assert property (
      $past(sys_rst_in) |-> thresh_sel_out == tsmsel_pkg::THR_130C)
      else $error("threshold not 130 after reset");

   chk_sensor_low_range: assert property (
      (range_sel < tsmsel_pkg::RANGE_25MA) |=>
         stage_sensor_sel_out == tsmsel_pkg::TSMSEL_SENS_ONE)
      else $error("low range did not pick stage one sensor");

   chk_trip_inhibits: assert property (
      trip_now |=> !force_enable_out && !dps1[tsmsel_pkg::DPS1_SOFT_INH])
      else $error("trip left force stage enabled");

   chk_alarm_sets: assert property (
      trip_now |=> alarm_flag && !overtemp_alarm_pin_oe_n_out)
      else $error("trip did not raise alarm");

   chk_status_clear: assert property (
      rd_alarm && !trip_now |=> !alarm_flag)
      else $error("status read did not clear alarm");

   chk_rearm_order: assert property (
      $rose(force_enable_out) |-> $past(wr_dps1) && !$past(alarm_flag))
      else $error("force stage re-enabled without proper sequence");

   chk_powerdown_quiet: assert property (
      power_down |=> !alarm_flag || $past(alarm_flag))
      else $error("alarm raised in power-down");

   chk_diode_route: assert property (
      wr_diag |=> ##1 diode_probe_sel_out == $past(wr_data[3:0], 2))
      else $error("diode select not routed");

   chk_unlatched_follow: assert property (
      !alarm_latched |=> overtemp_alarm_pin_oe_n_out == !$past(trip_now))
      else $error("unlatched alarm not following comparison");

   chk_latched_hold: assert property (
      alarm_latched && alarm_flag && !rd_alarm |=> !overtemp_alarm_pin_oe_n_out)
      else $error("latched alarm released early");

   chk_thresh_write: assert property (
      wr_dps2 |=> ##1 thresh_sel_out ==
         $past(wr_data[tsmsel_pkg::DPS2_THR_HI:tsmsel_pkg::DPS2_THR_LO], 2))
      else $error("threshold write not applied");

   chk_sensor_ext_two: assert property (
      (range_sel == tsmsel_pkg::RANGE_EXT2) |=>
         stage_sensor_sel_out == tsmsel_pkg::TSMSEL_SENS_TWO)
      else $error("second stage range did not pick its sensor");

   chk_trip_holds: assert property (
      trip_now |=> shutdown_hold)
      else $error("trip did not hold force stage off");

   chk_hold_blocks: assert property (
      shutdown_hold && !rearm |=> !force_enable_out)
      else $error("force stage enabled while shutdown held");

   chk_flag_sticks: assert property (
      alarm_flag && !rd_alarm |=> alarm_flag)
      else $error("alarm flag cleared without status read");

   chk_route_diag: assert property (
      wr_diag && wr_data[tsmsel_pkg::DIAG_MEAS_EN] |=> ##1 meas_route_out ==
         {1'b1,
          $past(wr_data[tsmsel_pkg::DIAG_NODE_HI:tsmsel_pkg::DIAG_NODE_LO], 2)})
      else $error("diagnostic node not routed");

   chk_route_direct: assert property (
      wr_dps1 && !diag_meas_en |=> ##1 meas_route_out ==
         {1'b0, $past(wr_data[tsmsel_pkg::DPS1_SRC_HI:tsmsel_pkg::DPS1_SRC_LO], 2)})
      else $error("measure source not routed");

   chk_low_range: assert property (
      wr_dps2 |=> ##1 meas_low_range_out == $past(wr_data[tsmsel_pkg::DPS2_LOW_RANGE], 2))
      else $error("low measure range not applied");

   chk_scale_write: assert property (
      wr_dps2 |=> ##1 output_scale_select_out == $past(wr_data[tsmsel_pkg::DPS2_SCALE], 2))
      else $error("output scale not applied");

   chk_gain_write: assert property (
      wr_dps2 |=> ##1 current_gain_select_out == $past(wr_data[tsmsel_pkg::DPS2_CUR_GAIN], 2))
      else $error("current gain not applied");

   chk_tristate_write: assert property (
      wr_dps1 |=> ##1 measure_output_tristate_out ==
         $past(wr_data[tsmsel_pkg::DPS1_MEAS_TRI], 2))
      else $error("measure tristate not applied");

   chk_diode_enable: assert property (
      wr_diag |=> ##1 diode_probe_enable_out == $past(wr_data[tsmsel_pkg::DIAG_DIODE_EN], 2))
      else $error("diode enable not applied");

   chk_sensor_power: assert property (
      wr_dps1 |=> ##1 stage_sensor_enable_out == !$past(wr_data[tsmsel_pkg::DPS1_PDOWN], 2))
      else $error("stage sensors not following power-down");

   cov_trip: cover property (trip_now ##1 !force_enable_out);
   cov_clear: cover property (alarm_flag ##1 rd_alarm ##1 !alarm_flag);
   cov_rearm: cover property (shutdown_hold ##[1:100] $rose(force_enable_out));
   cov_unlatched_free: cover property (!alarm_latched && trip_now ##[1:20] !trip_now);
   cov_diag_route: cover property (wr_diag ##2 meas_route_out[2]);
endmodule
`default_nettype wire

// File: verif/tsmsel_host_model.sv
/*
 tsmsel_host_model: host controller on the serial register port.
 Assumes the caller runs in the clk_sys_in domain, one frame at a time.
*/
`timescale 1ns/1ns
`default_nettype none
module tsmsel_host_model #(
   parameter int PHASE = 8
) (
   input  wire logic clk_sys_in,
   input  wire logic sdo_in,
   output logic      sclk_out,
   output logic      sdi_out,
   output logic      sync_n_out
);
   initial begin
      sclk_out   = 1'b0;
      sdi_out    = 1'b0;
      sync_n_out = 1'b1;
   end

   // one 24-bit frame, msb first; read data taken just before each rise
   task automatic xfer(input logic rd, input logic [6:0] addr, input logic [15:0] wd,
                       output logic [15:0] rdat);
      logic [23:0] fr;
      fr   = {rd, addr, wd};
      rdat = 16'h0000;
      @(posedge clk_sys_in);
      sync_n_out <= 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdi_out <= fr[i];
         repeat (PHASE - 1) @(posedge clk_sys_in);
         @(negedge clk_sys_in);
         if (i < 16) begin
            rdat[i] = sdo_in;
         end
         @(posedge clk_sys_in);
         sclk_out <= 1'b1;
         repeat (PHASE) @(posedge clk_sys_in);
         sclk_out <= 1'b0;
      end
      repeat (PHASE) @(posedge clk_sys_in);
      sync_n_out <= 1'b1;
      sdi_out    <= ~fr[0];
      repeat (PHASE) @(posedge clk_sys_in);
   endtask
endmodule
`default_nettype wire

// File: verif/tb_top.sv
/*
 tb_top: self-checking bench for the thermal shutdown and measure select block.
 Assumes the host model for serial frames; comparator levels driven here.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic        clk_sys_in;
   logic        sys_rst_in;
   logic        sclk;
   logic        sdi;
   logic        sync_n;
   logic [2:0]  stage_trip;
   logic        sdo;
   logic        sdo_oe_n;
   logic        force_en;
   logic        alarm_pin;
   logic        alarm_oe_n;
   logic [1:0]  thresh_sel;
   logic [1:0]  sens_sel;
   logic        sens_en;
   logic [2:0]  range_sel;
   logic [2:0]  route;
   logic        meas_tri;
   logic        low_range;
   logic        scale_sel;
   logic        gain_sel;
   logic        diode_en;
   logic [3:0]  diode_sel;
   int          miscompares = 0;
   int          checks_done = 0;
   int          cycles      = 0;

   tsmsel_host_model #(.PHASE(8)) i_host (.clk_sys_in(clk_sys_in), .sdo_in(sdo),
      .sclk_out(sclk), .sdi_out(sdi), .sync_n_out(sync_n));

   tsmsel_thermal_measure i_dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
      .sclk_in(sclk), .sdi_in(sdi), .sync_n_in(sync_n), .stage_trip_in(stage_trip),
      .sdo_out(sdo), .sdo_oe_n_out(sdo_oe_n), .force_enable_out(force_en),
      .overtemp_alarm_pin_out(alarm_pin), .overtemp_alarm_pin_oe_n_out(alarm_oe_n),
      .thresh_sel_out(thresh_sel), .stage_sensor_sel_out(sens_sel),
      .stage_sensor_enable_out(sens_en), .range_sel_out(range_sel),
      .meas_route_out(route), .measure_output_tristate_out(meas_tri),
      .meas_low_range_out(low_range), .output_scale_select_out(scale_sel),
      .current_gain_select_out(gain_sel), .diode_probe_enable_out(diode_en),
      .diode_probe_sel_out(diode_sel));

   task automatic final_report();
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic chk1(input logic seen, input logic exp);
      chk({15'h0000, seen}, {15'h0000, exp});
   endtask

   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      logic [15:0] unused;
      i_host.xfer(1'b0, a, d, unused);
   endtask

   task automatic rd(input logic [6:0] a, output logic [15:0] d);
      i_host.xfer(1'b1, a, 16'h0000, d);
   endtask

   // comparator level passes two sync stages and the output register
   task automatic settle();
      repeat (8) @(posedge clk_sys_in);
   endtask

   task automatic t_reset();
      logic [15:0] d;
      chk({14'h0000, thresh_sel}, {14'h0000, tsmsel_pkg::THR_130C});
      chk1(alarm_oe_n, 1'b1);
      chk1(alarm_pin, 1'b0);
      chk1(sdo_oe_n, 1'b1);
      rd(tsmsel_pkg::ADDR_DPS2, d);
      chk(d, tsmsel_pkg::DPS2_RESET);
      rd(7'h55, d);
      chk(d, 16'h0000);
   endtask

   task automatic t_ctrl2();
      logic [1:0] t;
      for (int i = 0; i < 4; i++) begin
         t = 2'(i);
         wr(tsmsel_pkg::ADDR_DPS2, {t, 1'b0, t[0], t[1], t[0], 10'h000});
         chk({14'h0000, thresh_sel}, {14'h0000, t});
         chk1(scale_sel, t[0]);
         chk1(gain_sel, t[1]);
         chk1(low_range, t[0]);
      end
   endtask

   task automatic t_ctrl1();
      logic [2:0] r;
      logic [1:0] e;
      for (int i = 0; i < 4; i++) begin
         r = 3'(i);
         wr(tsmsel_pkg::ADDR_DPS1, {2'b00, r[1:0], r[0], 11'h000});
         chk({13'h0000, route}, {13'h0000, 1'b0, r[1:0]});
         chk1(meas_tri, r[0]);
      end
      for (int i = 0; i < 7; i++) begin
         r = 3'(i);
         wr(tsmsel_pkg::ADDR_DPS1, {5'h00, r, 8'h00});
         e = (r == tsmsel_pkg::RANGE_25MA) ? 2'h3 : (r == tsmsel_pkg::RANGE_EXT2) ? 2'h1 : 2'h0;
         chk({13'h0000, range_sel}, {13'h0000, r});
         chk({14'h0000, sens_sel}, {14'h0000, e});
      end
   endtask

   task automatic t_diag();
      logic [1:0]  n;
      logic [15:0] v;
      logic [15:0] d;
      for (int i = 0; i < 4; i++) begin
         n = 2'(i);
         v = {1'b1, 1'b0, n, 7'h00, 1'b1, n, n};
         wr(tsmsel_pkg::ADDR_DIAG, v);
         chk({13'h0000, route}, {13'h0000, 1'b1, n});
         chk1(diode_en, 1'b1);
         chk({12'h000, diode_sel}, {12'h000, n, n});
         rd(tsmsel_pkg::ADDR_DIAG, d);
         chk(d, v & tsmsel_pkg::DIAG_MASK);
      end
      wr(tsmsel_pkg::ADDR_DIAG, 16'h0000);
      chk1(diode_en, 1'b0);
   endtask

   task automatic t_latched();
      logic [15:0] d;
      wr(tsmsel_pkg::ADDR_DPS2, 16'h2000);
      wr(tsmsel_pkg::ADDR_DPS1, 16'h8000);
      chk1(force_en, 1'b1);
      stage_trip <= 3'b001;
      settle();
      chk1(force_en, 1'b0);
      chk1(alarm_oe_n, 1'b0);
      rd(tsmsel_pkg::ADDR_DPS1, d);
      chk(d, 16'h0000);
      stage_trip <= 3'b000;
      settle();
      chk1(alarm_oe_n, 1'b0);
      wr(tsmsel_pkg::ADDR_DPS1, 16'h8000);
      chk1(force_en, 1'b0);
      rd(tsmsel_pkg::ADDR_ALARM, d);
      chk(d, 16'h0001);
      chk1(alarm_oe_n, 1'b1);
      rd(tsmsel_pkg::ADDR_ALARM, d);
      chk(d, 16'h0000);
      wr(tsmsel_pkg::ADDR_DPS1, 16'h8000);
      chk1(force_en, 1'b1);
   endtask

   task automatic t_unlatched();
      logic [15:0] d;
      wr(tsmsel_pkg::ADDR_DPS2, 16'h0000);
      wr(tsmsel_pkg::ADDR_DPS1, 16'h8400);
      chk1(sens_en, 1'b1);
      stage_trip <= 3'b001;
      settle();
      chk1(force_en, 1'b1);
      stage_trip <= 3'b100;
      settle();
      chk1(force_en, 1'b0);
      chk1(alarm_oe_n, 1'b0);
      stage_trip <= 3'b000;
      settle();
      chk1(alarm_oe_n, 1'b1);
      rd(tsmsel_pkg::ADDR_ALARM, d);
      chk(d, 16'h0001);
      wr(tsmsel_pkg::ADDR_DPS1, 16'hc000);
      chk1(sens_en, 1'b0);
      stage_trip <= 3'b001;
      settle();
      chk1(alarm_oe_n, 1'b1);
      stage_trip <= 3'b000;
      rd(tsmsel_pkg::ADDR_ALARM, d);
      chk(d, 16'h0000);
   endtask

   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end

   // hang guard: 38 frames of 401 cycles each fit well inside
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 60000) begin
         miscompares++;
         final_report();
      end
   end

   initial begin
      sys_rst_in = 1'b1;
      stage_trip = 3'b000;
      repeat (3) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      t_reset();
      t_ctrl2();
      t_ctrl1();
      t_diag();
      t_latched();
      t_unlatched();
      final_report();
   end
endmodule
`default_nettype wire
